// ---- apc_audio_regs.sv ----
`timescale 1ns/1ns
`include "apc_consts.svh"

module apc_audio_regs
	import apc_pkg::*;
(
	// clock and reset
	input  wire logic      clock,
	input  wire logic      resetn,
	// register port from the serial host port decoder
	input  wire apc_addr_t reg_addr,
	input  wire logic      reg_wr_en,
	input  wire apc_byte_t reg_wdata,
	input  wire logic      reg_rd_en,
	output apc_byte_t      reg_rdata,
	output logic           reg_rd_valid,
	output logic           reg_addr_err,
	// transmit amplifiers
	output logic [5:0]     tx_left_volume,
	output logic           tx_left_mute,
	output logic           tx_left_source_sel,
	output logic [5:0]     tx_right_volume,
	output logic           tx_right_mute,
	output logic           tx_right_source_sel,
	// microphone preamp and stereo transmit selection
	output logic [1:0]     second_mic_preamp_gain,
	output logic [1:0]     first_mic_preamp_gain,
	output logic           headset_detect_enable,
	output logic           first_mic_digital_mode,
	output logic           stereo_tx_right_source,
	output logic           stereo_tx_left_source,
	// voice and stereo ADC
	output logic [4:0]     voice_adc_gain,
	output logic           voice_adc_gain_reserved,
	output logic [2:0]     voice_clock_in_sel,
	output logic [2:0]     stereo_adc_gain_steps,
	output logic           stereo_adc_gain_enable,
	output logic [2:0]     stereo_clock_in_sel,
	// DAC volume and mute
	output logic [5:0]     voice_dac_volume,
	output logic           voice_dac_mute,
	output logic [5:0]     audio_dac_left_volume,
	output logic           audio_dac_left_mute,
	output logic [5:0]     audio_dac_right_volume,
	output logic           audio_dac_right_mute,
	// output mutes and left mixer
	output logic           earpiece_mute,
	output logic           headset_right_mute,
	output logic           headset_left_mute,
	output logic           left_mix_audio_dac,
	output logic           left_mix_voice_dac,
	output logic           left_mix_line_in
);

	localparam apc_addr_t OFS [`APC_NUM_REGS] = '{
		`APC_OFS_TX_LEFT, `APC_OFS_TX_RIGHT, `APC_OFS_MIC_PREAMP,
		`APC_OFS_VOICE_ADC, `APC_OFS_STEREO_ADC, `APC_OFS_VOICE_DAC,
		`APC_OFS_DAC_LEFT, `APC_OFS_DAC_RIGHT, `APC_OFS_OUT_MUTE
	};

	localparam apc_byte_t MASK [`APC_NUM_REGS] = '{
		`APC_MASK_TX_LEFT, `APC_MASK_TX_RIGHT, `APC_MASK_MIC_PREAMP,
		`APC_MASK_VOICE_ADC, `APC_MASK_STEREO_ADC, `APC_MASK_VOICE_DAC,
		`APC_MASK_DAC_LEFT, `APC_MASK_DAC_RIGHT, `APC_MASK_OUT_MUTE
	};

	logic [`APC_NUM_REGS-1:0] hit;
	logic [`APC_NUM_REGS-1:0] wr_sel;
	apc_byte_t                regv [`APC_NUM_REGS];
	apc_byte_t                hit_data [`APC_NUM_REGS];
	apc_byte_t                rd_mux;
	logic                     any_hit;
	apc_byte_t                rdata_reg;
	apc_byte_t                rdata_next;
	logic                     rd_valid_reg;
	logic                     addr_err_reg;
	logic                     addr_err_next;

	// one cell per register; the mask keeps reserved bits at zero
	genvar gi;
	generate
		for (gi = 0; gi < `APC_NUM_REGS; gi = gi + 1) begin : g_reg
			assign hit[gi]    = (reg_addr == OFS[gi]);
			assign wr_sel[gi] = reg_wr_en & hit[gi];
			apc_ctrl_byte #(
				.WR_MASK (MASK[gi])
			) u_byte (
				.clock  (clock),
				.resetn (resetn),
				.wr_en  (wr_sel[gi]),
				.wdata  (reg_wdata),
				.q      (regv[gi])
			);
			if (gi == 0) begin : g_first
				assign hit_data[gi] = hit[gi] ? regv[gi] : 8'h00;
			end else begin : g_rest
				assign hit_data[gi] = hit_data[gi-1] | (hit[gi] ? regv[gi] : 8'h00);
			end
		end
	endgenerate

	// read data is captured one edge after the request, unmapped reads return zero
	assign any_hit       = |hit;
	assign rd_mux        = hit_data[`APC_NUM_REGS-1];
	assign rdata_next    = reg_rd_en ? rd_mux : rdata_reg;
	assign addr_err_next = (reg_rd_en | reg_wr_en) & ~any_hit;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_reg    <= 8'h00;
			rd_valid_reg <= 1'b0;
			addr_err_reg <= 1'b0;
		end else begin
			rdata_reg    <= rdata_next;
			rd_valid_reg <= reg_rd_en;
			addr_err_reg <= addr_err_next;
		end
	end

	assign reg_rdata    = rdata_reg;
	assign reg_rd_valid = rd_valid_reg;
	assign reg_addr_err = addr_err_reg;

	// transmit amplifiers
	assign tx_left_volume      = regv[APC_IDX_TX_LEFT][`APC_VOL_MSB:`APC_VOL_LSB];
	assign tx_left_mute        = regv[APC_IDX_TX_LEFT][`APC_AMP_MUTE_BIT];
	assign tx_left_source_sel  = regv[APC_IDX_TX_LEFT][`APC_AMP_SEL_BIT];
	assign tx_right_volume     = regv[APC_IDX_TX_RIGHT][`APC_VOL_MSB:`APC_VOL_LSB];
	assign tx_right_mute       = regv[APC_IDX_TX_RIGHT][`APC_AMP_MUTE_BIT];
	assign tx_right_source_sel = regv[APC_IDX_TX_RIGHT][`APC_AMP_SEL_BIT];

	// microphone preamp
	assign second_mic_preamp_gain = regv[APC_IDX_MIC_PREAMP][`APC_MIC2_GAIN_MSB:`APC_MIC2_GAIN_LSB];
	assign first_mic_preamp_gain  = regv[APC_IDX_MIC_PREAMP][`APC_MIC1_GAIN_MSB:`APC_MIC1_GAIN_LSB];
	assign headset_detect_enable  = regv[APC_IDX_MIC_PREAMP][`APC_HS_DET_BIT];
	assign first_mic_digital_mode = regv[APC_IDX_MIC_PREAMP][`APC_MIC1_DIG_BIT];
	assign stereo_tx_right_source = regv[APC_IDX_MIC_PREAMP][`APC_TX_RIGHT_BIT];
	assign stereo_tx_left_source  = regv[APC_IDX_MIC_PREAMP][`APC_TX_LEFT_BIT];

	// reserved gain codes are stored as written; the flag lets the analog side hold its setting
	assign voice_adc_gain          = regv[APC_IDX_VOICE_ADC][`APC_VGAIN_MSB:`APC_VGAIN_LSB];
	assign voice_adc_gain_reserved = voice_adc_gain > `APC_VGAIN_TOP_CODE;
	assign voice_clock_in_sel      = regv[APC_IDX_VOICE_ADC][`APC_VCLK_MSB:`APC_VCLK_LSB];
	assign stereo_adc_gain_steps   = regv[APC_IDX_STEREO_ADC][`APC_SGAIN_MSB:`APC_SGAIN_LSB];
	assign stereo_adc_gain_enable  = regv[APC_IDX_STEREO_ADC][`APC_SGAIN_EN_BIT];
	assign stereo_clock_in_sel     = regv[APC_IDX_STEREO_ADC][`APC_SCLK_MSB:`APC_SCLK_LSB];

	// DAC volume and mute
	assign voice_dac_volume       = regv[APC_IDX_VOICE_DAC][`APC_VOL_MSB:`APC_VOL_LSB];
	assign voice_dac_mute         = regv[APC_IDX_VOICE_DAC][`APC_DAC_MUTE_BIT];
	assign audio_dac_left_volume  = regv[APC_IDX_DAC_LEFT][`APC_VOL_MSB:`APC_VOL_LSB];
	assign audio_dac_left_mute    = regv[APC_IDX_DAC_LEFT][`APC_DAC_MUTE_BIT];
	assign audio_dac_right_volume = regv[APC_IDX_DAC_RIGHT][`APC_VOL_MSB:`APC_VOL_LSB];
	assign audio_dac_right_mute   = regv[APC_IDX_DAC_RIGHT][`APC_DAC_MUTE_BIT];

	// output mutes and left mixer routing
	assign earpiece_mute      = regv[APC_IDX_OUT_MUTE][`APC_EAR_MUTE_BIT];
	assign headset_right_mute = regv[APC_IDX_OUT_MUTE][`APC_HSR_MUTE_BIT];
	assign headset_left_mute  = regv[APC_IDX_OUT_MUTE][`APC_HSL_MUTE_BIT];
	assign left_mix_audio_dac = regv[APC_IDX_OUT_MUTE][`APC_MIX_ADAC_BIT];
	assign left_mix_voice_dac = regv[APC_IDX_OUT_MUTE][`APC_MIX_VDAC_BIT];
	assign left_mix_line_in   = regv[APC_IDX_OUT_MUTE][`APC_MIX_LINE_BIT];

	// checks

	a_tx_left_fields: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_TX_LEFT) |=>
		(tx_left_volume == $past(reg_wdata[5:0])) && (tx_left_mute == $past(reg_wdata[6])))
		else $error("left transmit volume or mute not taken from write");

	a_tx_left_source: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_TX_LEFT) ##1 (!reg_wr_en)[*2] |->
		tx_left_source_sel == $past(reg_wdata[7], 2))
		else $error("left transmit source select lost after write");

	a_tx_right_fields: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_TX_RIGHT) |=>
		(tx_right_volume == $past(reg_wdata[5:0])) && (tx_right_mute == $past(reg_wdata[6])))
		else $error("right transmit volume or mute not taken from write");

	a_tx_right_source: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_TX_RIGHT) |=> tx_right_source_sel == $past(reg_wdata[7]))
		else $error("right transmit source select wrong");

	a_mic_gains: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_MIC_PREAMP) |=>
		(second_mic_preamp_gain == $past(reg_wdata[1:0])) && (first_mic_preamp_gain == $past(reg_wdata[3:2])))
		else $error("microphone preamp gains misplaced");

	a_mic_flags: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_MIC_PREAMP) |=>
		(headset_detect_enable == $past(reg_wdata[4])) && (first_mic_digital_mode == $past(reg_wdata[5])))
		else $error("headset detect or mic mode bit wrong");

	a_stereo_tx_sel: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_MIC_PREAMP) |=>
		(stereo_tx_right_source == $past(reg_wdata[6])) && (stereo_tx_left_source == $past(reg_wdata[7])))
		else $error("stereo transmit channel selectors wrong");

	a_voice_gain: assert property (@(posedge clock) disable iff (!resetn)
		voice_adc_gain_reserved == (voice_adc_gain[4] == 1'b1))
		else $error("voice gain reserved flag wrong");

	a_voice_clock: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_VOICE_ADC) |=>
		(voice_clock_in_sel == $past(reg_wdata[7:5])) && (voice_adc_gain == $past(reg_wdata[4:0])))
		else $error("voice ADC register fields wrong");

	a_stereo_fields: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_STEREO_ADC) |=>
		(stereo_clock_in_sel == $past(reg_wdata[6:4])) && (stereo_adc_gain_enable == $past(reg_wdata[3]))
		&& (stereo_adc_gain_steps == $past(reg_wdata[2:0])))
		else $error("stereo ADC register fields wrong");

	a_voice_dac: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_VOICE_DAC) |=>
		(voice_dac_volume == $past(reg_wdata[5:0])) && (voice_dac_mute == $past(reg_wdata[7])))
		else $error("voice DAC volume or mute wrong");

	a_dac_left: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_DAC_LEFT) |=>
		(audio_dac_left_volume == $past(reg_wdata[5:0])) && (audio_dac_left_mute == $past(reg_wdata[7])))
		else $error("left audio DAC fields wrong");

	a_dac_right: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_DAC_RIGHT) |=>
		(audio_dac_right_volume == $past(reg_wdata[5:0])) && (audio_dac_right_mute == $past(reg_wdata[7])))
		else $error("right audio DAC fields wrong");

	a_out_mutes: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_OUT_MUTE) |=>
		(earpiece_mute == $past(reg_wdata[0])) && (headset_right_mute == $past(reg_wdata[1]))
		&& (headset_left_mute == $past(reg_wdata[2])))
		else $error("output amplifier mutes wrong");

	a_left_mixer: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_OUT_MUTE) |=>
		(left_mix_audio_dac == $past(reg_wdata[4])) && (left_mix_voice_dac == $past(reg_wdata[5]))
		&& (left_mix_line_in == $past(reg_wdata[7])))
		else $error("left mixer routing wrong");

	a_read_back: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_TX_LEFT) ##1 (reg_rd_en && !reg_wr_en && reg_addr == `APC_OFS_TX_LEFT)
		|=> reg_rd_valid && reg_rdata == $past(reg_wdata, 2))
		else $error("register does not read back written value");

	a_reset_zero: assert property (@(posedge clock)
		!resetn |=> !resetn || (tx_left_volume == 6'h00 && voice_dac_mute == 1'b0 && earpiece_mute == 1'b0
		&& stereo_clock_in_sel == 3'h0 && left_mix_line_in == 1'b0))
		else $error("register not zero after reset");

	a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
		reg_rd_valid && $past(reg_addr) == `APC_OFS_OUT_MUTE |-> reg_rdata[3] == 1'b0 && reg_rdata[6] == 1'b0)
		else $error("reserved bit reads back as one");

	a_unmapped_read: assert property (@(posedge clock) disable iff (!resetn)
		(reg_rd_en && reg_addr > `APC_OFS_OUT_MUTE) |=> reg_addr_err && reg_rdata == 8'h00)
		else $error("unmapped read not flagged or not zero");

	a_hold_tx_left: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_wr_en && reg_addr == `APC_OFS_TX_LEFT) |=>
		$stable({tx_left_source_sel, tx_left_mute, tx_left_volume}))
		else $error("left transmit control changed without a write");

	a_hold_tx_right: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_wr_en && reg_addr == `APC_OFS_TX_RIGHT) |=>
		$stable({tx_right_source_sel, tx_right_mute, tx_right_volume}))
		else $error("right transmit control changed without a write");

	a_hold_mic: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_wr_en && reg_addr == `APC_OFS_MIC_PREAMP) |=>
		$stable({stereo_tx_left_source, stereo_tx_right_source, first_mic_digital_mode, headset_detect_enable,
		first_mic_preamp_gain, second_mic_preamp_gain}))
		else $error("preamp register changed without a write");

	a_hold_voice_adc: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_wr_en && reg_addr == `APC_OFS_VOICE_ADC) |=>
		$stable({voice_clock_in_sel, voice_adc_gain, voice_adc_gain_reserved}))
		else $error("voice ADC register changed without a write");

	a_hold_stereo_adc: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_wr_en && reg_addr == `APC_OFS_STEREO_ADC) |=>
		$stable({stereo_clock_in_sel, stereo_adc_gain_enable, stereo_adc_gain_steps}))
		else $error("stereo ADC register changed without a write");

	a_hold_voice_dac: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_wr_en && reg_addr == `APC_OFS_VOICE_DAC) |=>
		$stable({voice_dac_mute, voice_dac_volume}))
		else $error("voice DAC register changed without a write");

	a_hold_dac_left: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_wr_en && reg_addr == `APC_OFS_DAC_LEFT) |=>
		$stable({audio_dac_left_mute, audio_dac_left_volume}))
		else $error("left audio DAC register changed without a write");

	a_hold_dac_right: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_wr_en && reg_addr == `APC_OFS_DAC_RIGHT) |=>
		$stable({audio_dac_right_mute, audio_dac_right_volume}))
		else $error("right audio DAC register changed without a write");

	a_hold_out_mute: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_wr_en && reg_addr == `APC_OFS_OUT_MUTE) |=>
		$stable({left_mix_line_in, left_mix_voice_dac, left_mix_audio_dac, headset_left_mute, headset_right_mute,
		earpiece_mute}))
		else $error("output mute register changed without a write");

	a_rd_valid_set: assert property (@(posedge clock) disable iff (!resetn)
		reg_rd_en |=> reg_rd_valid)
		else $error("read valid missing after read");

	a_rd_data_hold: assert property (@(posedge clock) disable iff (!resetn)
		!reg_rd_en |=> !reg_rd_valid && $stable(reg_rdata))
		else $error("read data or valid moved without a read");

	a_err_idle: assert property (@(posedge clock) disable iff (!resetn)
		!(reg_rd_en || reg_wr_en) |=> !reg_addr_err)
		else $error("address error without an access");

	a_err_mapped: assert property (@(posedge clock) disable iff (!resetn)
		(reg_rd_en || reg_wr_en) && reg_addr >= `APC_OFS_TX_LEFT && reg_addr <= `APC_OFS_OUT_MUTE |=>
		!reg_addr_err)
		else $error("address error on a mapped register");

	a_err_below: assert property (@(posedge clock) disable iff (!resetn)
		(reg_rd_en || reg_wr_en) && reg_addr < `APC_OFS_TX_LEFT |=> reg_addr_err)
		else $error("access below the bank not flagged");

	a_dac_reserved: assert property (@(posedge clock) disable iff (!resetn)
		reg_rd_valid && $past(reg_addr) >= `APC_OFS_VOICE_DAC && $past(reg_addr) <= `APC_OFS_DAC_RIGHT |->
		reg_rdata[6] == 1'b0)
		else $error("DAC register reserved bit reads back as one");

	a_stereo_reserved: assert property (@(posedge clock) disable iff (!resetn)
		reg_rd_valid && $past(reg_addr) == `APC_OFS_STEREO_ADC |-> reg_rdata[7] == 1'b0)
		else $error("stereo ADC reserved bit reads back as one");

	a_read_old: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_rd_en && reg_addr == `APC_OFS_DAC_LEFT) |=> reg_rdata == $past(regv[APC_IDX_DAC_LEFT]))
		else $error("read beside a write did not return the old value");

	a_voice_code_kept: assert property (@(posedge clock) disable iff (!resetn)
		(reg_wr_en && reg_addr == `APC_OFS_VOICE_ADC && reg_wdata[4]) |=>
		voice_adc_gain_reserved && voice_adc_gain == $past(reg_wdata[4:0]))
		else $error("reserved voice gain code not kept or not flagged");

	a_reset_port: assert property (@(posedge clock)
		!resetn |=> !resetn || (!reg_rd_valid && !reg_addr_err && reg_rdata == 8'h00))
		else $error("read port not idle after reset");

endmodule

// ---- apc_consts.svh ----
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH

`define APC_NUM_REGS        9
`define APC_ADDR_W          9

`define APC_OFS_TX_LEFT     9'h189
`define APC_OFS_TX_RIGHT    9'h18A
`define APC_OFS_MIC_PREAMP  9'h18B
`define APC_OFS_VOICE_ADC   9'h18C
`define APC_OFS_STEREO_ADC  9'h18D
`define APC_OFS_VOICE_DAC   9'h18E
`define APC_OFS_DAC_LEFT    9'h18F
`define APC_OFS_DAC_RIGHT   9'h190
`define APC_OFS_OUT_MUTE    9'h191

`define APC_RESET_VALUE     8'h00

`define APC_MASK_TX_LEFT    8'hFF
`define APC_MASK_TX_RIGHT   8'hFF
`define APC_MASK_MIC_PREAMP 8'hFF
`define APC_MASK_VOICE_ADC  8'hFF
`define APC_MASK_STEREO_ADC 8'h7F
`define APC_MASK_VOICE_DAC  8'hBF
`define APC_MASK_DAC_LEFT   8'hBF
`define APC_MASK_DAC_RIGHT  8'hBF
`define APC_MASK_OUT_MUTE   8'hB7

`define APC_VOL_MSB         5
`define APC_VOL_LSB         0
`define APC_AMP_MUTE_BIT    6
`define APC_AMP_SEL_BIT     7
`define APC_DAC_MUTE_BIT    7

`define APC_MIC2_GAIN_MSB   1
`define APC_MIC2_GAIN_LSB   0
`define APC_MIC1_GAIN_MSB   3
`define APC_MIC1_GAIN_LSB   2
`define APC_HS_DET_BIT      4
`define APC_MIC1_DIG_BIT    5
`define APC_TX_RIGHT_BIT    6
`define APC_TX_LEFT_BIT     7

`define APC_VGAIN_MSB       4
`define APC_VGAIN_LSB       0
`define APC_VGAIN_TOP_CODE  5'h0F
`define APC_VCLK_MSB        7
`define APC_VCLK_LSB        5

`define APC_SGAIN_MSB       2
`define APC_SGAIN_LSB       0
`define APC_SGAIN_EN_BIT    3
`define APC_SCLK_MSB        6
`define APC_SCLK_LSB        4

`define APC_EAR_MUTE_BIT    0
`define APC_HSR_MUTE_BIT    1
`define APC_HSL_MUTE_BIT    2
`define APC_MIX_ADAC_BIT    4
`define APC_MIX_VDAC_BIT    5
`define APC_MIX_LINE_BIT    7

`endif

// ---- apc_ctrl_byte.sv ----
`timescale 1ns/1ns
`include "apc_consts.svh"

module apc_ctrl_byte
	import apc_pkg::*;
#(
	parameter apc_byte_t WR_MASK = 8'hFF
) (
	// clock and reset
	input  wire logic      clock,
	input  wire logic      resetn,
	// write side
	input  wire logic      wr_en,
	input  wire apc_byte_t wdata,
	// stored value
	output apc_byte_t      q
);

	apc_byte_t q_reg;
	apc_byte_t q_next;

	// reserved positions are masked on the way in, so they can never hold a one
	assign q_next = wr_en ? (wdata & WR_MASK) : q_reg;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			q_reg <= `APC_RESET_VALUE;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;

endmodule

// ---- apc_host_model.sv ----
`timescale 1ns/1ns

module apc_host_model
	import apc_pkg::*;
(
	// clock
	input  wire logic clock,
	// register port toward the device
	output apc_addr_t reg_addr,
	output logic      reg_wr_en,
	output apc_byte_t reg_wdata,
	output logic      reg_rd_en
);
	initial begin
		reg_addr  = 9'h000;
		reg_wr_en = 1'b0;
		reg_wdata = 8'h00;
		reg_rd_en = 1'b0;
	end

	// one bus cycle, entered just after an edge and left just after the edge that takes it;
	// idle cycles drive inverted leftovers so a stale address or data never looks valid
	task automatic cyc(input logic w, input logic r, input apc_addr_t a, input apc_byte_t d);
		reg_wr_en = w;
		reg_rd_en = r;
		reg_addr  = (w | r) ? a : ~reg_addr;
		reg_wdata = w ? d : ~reg_wdata;
		@(posedge clock);
		#1;
	endtask
endmodule

// ---- apc_pkg.sv ----
package apc_pkg;

	typedef logic [7:0] apc_byte_t;

	typedef logic [8:0] apc_addr_t;

	typedef enum logic [3:0] {
		APC_IDX_TX_LEFT     = 4'h0,
		APC_IDX_TX_RIGHT    = 4'h1,
		APC_IDX_MIC_PREAMP  = 4'h2,
		APC_IDX_VOICE_ADC   = 4'h3,
		APC_IDX_STEREO_ADC  = 4'h4,
		APC_IDX_VOICE_DAC   = 4'h5,
		APC_IDX_DAC_LEFT    = 4'h6,
		APC_IDX_DAC_RIGHT   = 4'h7,
		APC_IDX_OUT_MUTE    = 4'h8
	} apc_reg_idx_t;

endpackage

// ---- testbench.sv ----
`timescale 1ns/1ns

module testbench;
	import apc_pkg::*;

	logic      clock;
	logic      resetn;
	apc_addr_t reg_addr;
	logic      reg_wr_en;
	logic      reg_rd_en;
	apc_byte_t reg_wdata;
	apc_byte_t reg_rdata;
	logic      reg_rd_valid;
	logic      reg_addr_err;
	logic [5:0] tx_left_volume, tx_right_volume, voice_dac_volume, audio_dac_left_volume, audio_dac_right_volume;
	logic [4:0] voice_adc_gain;
	logic [2:0] voice_clock_in_sel, stereo_adc_gain_steps, stereo_clock_in_sel;
	logic [1:0] second_mic_preamp_gain, first_mic_preamp_gain;
	logic       tx_left_mute, tx_left_source_sel, tx_right_mute, tx_right_source_sel, headset_detect_enable;
	logic       first_mic_digital_mode, stereo_tx_right_source, stereo_tx_left_source, voice_adc_gain_reserved;
	logic       stereo_adc_gain_enable, voice_dac_mute, audio_dac_left_mute, audio_dac_right_mute;
	logic       earpiece_mute, headset_right_mute, headset_left_mute;
	logic       left_mix_audio_dac, left_mix_voice_dac, left_mix_line_in;
	int         n_mismatch = 0;
	int         n_compared = 0;
	apc_byte_t  fld [9];

	localparam apc_addr_t BASE = 9'h189;
	// bits that store a value; reserved bits must stay zero
	localparam apc_byte_t MASK [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hBF, 8'hBF, 8'hBF, 8'hB7};

	// field outputs put back together in documented bit order
	assign fld[0] = {tx_left_source_sel, tx_left_mute, tx_left_volume};
	assign fld[1] = {tx_right_source_sel, tx_right_mute, tx_right_volume};
	assign fld[2] = {stereo_tx_left_source, stereo_tx_right_source, first_mic_digital_mode, headset_detect_enable,
		first_mic_preamp_gain, second_mic_preamp_gain};
	assign fld[3] = {voice_clock_in_sel, voice_adc_gain};
	assign fld[4] = {1'b0, stereo_clock_in_sel, stereo_adc_gain_enable, stereo_adc_gain_steps};
	assign fld[5] = {voice_dac_mute, 1'b0, voice_dac_volume};
	assign fld[6] = {audio_dac_left_mute, 1'b0, audio_dac_left_volume};
	assign fld[7] = {audio_dac_right_mute, 1'b0, audio_dac_right_volume};
	assign fld[8] = {left_mix_line_in, 1'b0, left_mix_voice_dac, left_mix_audio_dac, 1'b0, headset_left_mute,
		headset_right_mute, earpiece_mute};

	apc_host_model HOST (.clock, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en);

	apc_audio_regs DUT (.clock, .resetn, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rd_valid,
		.reg_addr_err, .tx_left_volume, .tx_left_mute, .tx_left_source_sel, .tx_right_volume, .tx_right_mute,
		.tx_right_source_sel, .second_mic_preamp_gain, .first_mic_preamp_gain, .headset_detect_enable,
		.first_mic_digital_mode, .stereo_tx_right_source, .stereo_tx_left_source, .voice_adc_gain,
		.voice_adc_gain_reserved, .voice_clock_in_sel, .stereo_adc_gain_steps, .stereo_adc_gain_enable,
		.stereo_clock_in_sel, .voice_dac_volume, .voice_dac_mute, .audio_dac_left_volume, .audio_dac_left_mute,
		.audio_dac_right_volume, .audio_dac_right_mute, .earpiece_mute, .headset_right_mute, .headset_left_mute,
		.left_mix_audio_dac, .left_mix_voice_dac, .left_mix_line_in);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input apc_byte_t exp, input apc_byte_t got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// read data and valid stand for the cycle right after the taking edge
	task automatic rd(input apc_addr_t a, output apc_byte_t d);
		HOST.cyc(1'b0, 1'b1, a, 8'h00);
		d = reg_rdata;
		chk("read valid", 8'h01, {7'h00, reg_rd_valid});
	endtask

	task automatic idle();
		HOST.cyc(1'b0, 1'b0, 9'h000, 8'h00);
	endtask

	task automatic sc_reset_values();
		apc_byte_t d;
		for (int i = 0; i < 9; i++) begin
			rd(BASE + 9'(i), d);
			chk("reset readback", 8'h00, d);
			chk("reset fields", 8'h00, fld[i]);
		end
		idle();
	endtask

	// back-to-back writes to every register, each value distinct per register
	task automatic sc_fields(input apc_byte_t pat);
		apc_byte_t d;
		for (int i = 0; i < 9; i++) begin
			HOST.cyc(1'b1, 1'b0, BASE + 9'(i), pat ^ 8'(i));
			chk("mapped write error", 8'h00, {7'h00, reg_addr_err});
		end
		chk("tx left fields", pat & MASK[0], fld[0]);
		chk("tx right fields", (pat ^ 8'h01) & MASK[1], fld[1]);
		chk("mic preamp fields", (pat ^ 8'h02) & MASK[2], fld[2]);
		chk("voice adc fields", (pat ^ 8'h03) & MASK[3], fld[3]);
		chk("stereo adc fields", (pat ^ 8'h04) & MASK[4], fld[4]);
		chk("voice dac fields", (pat ^ 8'h05) & MASK[5], fld[5]);
		chk("left dac fields", (pat ^ 8'h06) & MASK[6], fld[6]);
		chk("right dac fields", (pat ^ 8'h07) & MASK[7], fld[7]);
		chk("output mute fields", (pat ^ 8'h08) & MASK[8], fld[8]);
		for (int i = 0; i < 9; i++) begin
			rd(BASE + 9'(i), d);
			chk("readback", (pat ^ 8'(i)) & MASK[i], d);
		end
		idle();
	endtask

	task automatic sc_voice_reserved();
		HOST.cyc(1'b1, 1'b0, 9'h18C, 8'h10);
		chk("gain reserved flag", 8'h01, {7'h00, voice_adc_gain_reserved});
		HOST.cyc(1'b1, 1'b0, 9'h18C, 8'h0F);
		chk("gain top code flag", 8'h00, {7'h00, voice_adc_gain_reserved});
		chk("gain top code", 8'h0F, {3'h0, voice_adc_gain});
		idle();
	endtask

	// neighbours of the bank and far addresses must be refused
	task automatic sc_unmapped();
		apc_addr_t bad [4] = '{9'h188, 9'h192, 9'h000, 9'h1FF};
		apc_byte_t snap [9];
		apc_byte_t d;
		snap = fld;
		foreach (bad[k]) begin
			HOST.cyc(1'b1, 1'b0, bad[k], 8'hFF);
			chk("write error pulse", 8'h01, {7'h00, reg_addr_err});
			rd(bad[k], d);
			chk("unmapped read", 8'h00, d);
			chk("read error pulse", 8'h01, {7'h00, reg_addr_err});
		end
		idle();
		chk("error pulse ends", 8'h00, {7'h00, reg_addr_err});
		for (int i = 0; i < 9; i++) begin
			chk("bank untouched", snap[i], fld[i]);
		end
	endtask

	task automatic sc_back_to_back();
		apc_byte_t d;
		HOST.cyc(1'b1, 1'b1, 9'h18F, 8'h7C);
		chk("read beside write", (8'h5A ^ 8'h06) & MASK[6], reg_rdata);
		rd(9'h18F, d);
		chk("read after write", 8'h3C, d);
		HOST.cyc(1'b1, 1'b0, 9'h189, 8'hC5);
		chk("left transmit fields", 8'hC5, fld[0]);
		rd(9'h189, d);
		chk("read right after write", 8'hC5, d);
		idle();
	endtask

	// reset in mid-run clears at once, without waiting for an edge
	task automatic sc_mid_reset();
		apc_byte_t d;
		HOST.cyc(1'b1, 1'b0, 9'h191, 8'hFF);
		idle();
		resetn = 1'b0;
		#2;
		for (int i = 0; i < 9; i++) begin
			chk("fields in reset", 8'h00, fld[i]);
		end
		@(posedge clock);
		#1;
		resetn = 1'b1;
		rd(9'h191, d);
		chk("value after reset", 8'h00, d);
		idle();
	endtask

	initial begin
		resetn = 1'b0;
		repeat (8) @(posedge clock);
		#1;
		resetn = 1'b1;
		sc_reset_values();
		sc_fields(8'hA5);
		sc_fields(8'h5A);
		sc_unmapped();
		sc_back_to_back();
		sc_voice_reserved();
		sc_mid_reset();
		test_done();
	end

	// hang guard
	initial begin
		#100000;
		n_mismatch++;
		$display("CHECK FAILED run length expected done seen hang");
		test_done();
	end
endmodule
